// file: hw/pcr_top.sv
// Purpose: Power control registers and real-time clock tick divider
// Assumes: Analog status inputs are asynchronous; one 100 MHz clock
// Notes: All analog controls are static register fields or decoded flops
//
// Functional notes
// [R1] Control bit 15 picks manual or automatic rail switch, automatic only in boost.
// [R2] Control bit 2 closes the rail switch manually; resets open.
// [R3] Bits 8, 4, 3: pump off, core regulator off, retention on; reset 0.
// [R4] Bit 7 forces regulator references into hold; resets 0.
// [R5] Bits 6:5 decode low regulator current in active and sleep.
// [R6] Converter level bits 10:9 reset 01; offset bits 13:11 reset 011.
// [R7] Crystal regulator offset bits 6:4 in 25 mV steps; reset 011.
// [R8] Low regulator offset bits 3:1, same table; reset 111.
// [R9] Divider bit 21 requests clock module reset while set.
// [R10] Divider bit 20 enables ticks; cleared means no ticks at all.
// [R11] Divider bit 19 picks sequence of 1000 or 1024 periods.
// [R12] Bits 18:10 hold integer divisor, reset 0x147.
// [R13] Bits 9:0 hold fractional count of stretched periods, reset 0x2A8.
// [R14] With 1024 sequence, fraction periods last integer plus one cycles.
// [R15] With 1000 sequence, fraction periods last integer plus one cycles.
// [R16] Rail monitor disable, hysteresis and comparator enable bits are plain flags.
// [R17] Stretched periods spread by accumulator; tick is one-cycle pulse.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module pcr_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [pcr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [pcr_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pcr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [pcr_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic boostMode,
  input wire logic railAutoCloseReq,
  input wire logic sleepActive,
  output logic railSwitchClosed,
  output logic hiRailMonitorOff,
  output logic hiRailMonitorHystOff,
  output logic hiRailMonitorHystLevel,
  output logic loRailMonitorOff,
  output logic loRailMonitorHystOff,
  output logic loRailMonitorHystLevel,
  output logic hiRailOkCmpEnable,
  output logic hiRailNokCmpEnable,
  output logic corePumpOff,
  output logic referenceHoldForce,
  output logic coreRegulatorOff,
  output logic coreRegulatorRetentionOn,
  output logic lowRegulatorOn,
  output logic lowRegulatorHighCurrent,
  output logic [1:0] converterLevelSelect,
  output logic [2:0] converterLevelOffset,
  output logic [2:0] crystalRegulatorOffset,
  output logic [2:0] lowRegulatorOffset,
  output logic rtcResetReq,
  output logic rtcTick
);
  import pcr_pkg::*;

  logic wrReq, wrHit, rdReq, rdHit, tickPulse;
  logic [IDX_W-1:0] wrIdx, rdIdx;
  logic [DATA_W-1:0] wrData, rdData;
  logic [3:0] wrStrb;
  logic [DATA_W-1:0] pc_reg, pc_next, pl_reg, pl_next, td_reg, td_next;
  logic [SYNC_W-1:0] syncA_reg, syncB_reg;
  logic boostSync, autoReqSync, sleepSync;
  logic switch_reg, switch_next, lowOn_reg, lowOn_next, lowHi_reg, lowHi_next;
  logic tick_reg, tick_next;
  logic [TCNT_W-1:0] tcnt_reg, tcnt_next;
  pcr_low_mode_type lowMode;

  // Byte-lane merge limited to the implemented bits of each register
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] data,
    input logic [3:0] strb,
    input logic [DATA_W-1:0] mask
  );
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  pcr_axil_slave u_bus (
    .clk(clk),
    .rst_n(rst_n),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wrReq(wrReq),
    .wrIdx(wrIdx),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrHit(wrHit),
    .rdReq(rdReq),
    .rdIdx(rdIdx),
    .rdData(rdData),
    .rdHit(rdHit)
  );

  pcr_tick_div u_div (
    .clk(clk),
    .rst_n(rst_n),
    .enable(td_reg[TD_EN]), // [R10]
    .denomSel(td_reg[TD_DENOM]), // [R11]
    .intDiv(td_reg[TD_INT +: INT_W]), // [R12]
    .fracDiv(td_reg[TD_FRAC +: FRAC_W]), // [R13]
    .tick(tickPulse)
  );

  // Analog status levels: the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
    end else begin
      syncA_reg <= {sleepActive, railAutoCloseReq, boostMode};
      syncB_reg <= syncA_reg;
    end
  end

  assign boostSync = syncB_reg[0];
  assign autoReqSync = syncB_reg[1];
  assign sleepSync = syncB_reg[2];

  // Register writes
  always_comb begin
    pc_next = pc_reg;
    pl_next = pl_reg;
    td_next = td_reg;
    wrHit = 1'b0;
    if (wrReq) begin
      case (wrIdx)
        PC_SEL: begin
          pc_next = merge(pc_reg, wrData, wrStrb, PC_MASK); // [R16]
          wrHit = 1'b1;
        end
        PL_SEL: begin
          pl_next = merge(pl_reg, wrData, wrStrb, PL_MASK);
          wrHit = 1'b1;
        end
        TD_SEL: begin
          td_next = merge(td_reg, wrData, wrStrb, TD_MASK);
          wrHit = 1'b1;
        end
        ST_SEL: begin
          // Status is read only; writes are acknowledged and dropped
          wrHit = 1'b1;
        end
        default: begin
          wrHit = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_reg <= PC_RESET; // [R2] [R3] [R4]
      pl_reg <= PL_RESET; // [R6] [R7] [R8]
      td_reg <= TD_RESET; // [R12] [R13]
    end else begin
      pc_reg <= pc_next;
      pl_reg <= pl_next;
      td_reg <= td_next;
    end
  end

  // Register reads
  // Boost, request and sleep bits are synced levels, so they trail the pins by two cycles; the switch bit by three
  always_comb begin
    rdData = '0;
    rdHit = 1'b1;
    case (rdIdx)
      PC_SEL: rdData = pc_reg;
      PL_SEL: rdData = pl_reg;
      TD_SEL: rdData = td_reg;
      ST_SEL: begin
        rdData[ST_BOOST] = boostSync;
        rdData[ST_AUTO_REQ] = autoReqSync;
        rdData[ST_SWITCH] = switch_reg;
        rdData[ST_SLEEP] = sleepSync;
        rdData[ST_TCNT +: TCNT_W] = tcnt_reg;
      end
      default: rdHit = 1'b0;
    endcase
  end

  // Decoded analog controls and tick bookkeeping
  always_comb begin
    lowMode = pcr_low_mode_type'(pc_reg[PC_LOW_MODE +: 2]);
    // Automatic mode is honoured only while the converter boosts
    if (pc_reg[PC_AUTO] && boostSync) begin // [R1]
      switch_next = autoReqSync;
    end else begin
      switch_next = pc_reg[PC_CLOSE]; // [R2]
    end
    case (lowMode) // [R5]
      LOW_HI_OFF: begin
        lowOn_next = !sleepSync;
        lowHi_next = !sleepSync;
      end
      LOW_OFF: begin
        lowOn_next = 1'b0;
        lowHi_next = 1'b0;
      end
      LOW_LO_LO: begin
        lowOn_next = 1'b1;
        lowHi_next = 1'b0;
      end
      LOW_HI_LO: begin
        lowOn_next = 1'b1;
        lowHi_next = !sleepSync;
      end
      default: begin
        lowOn_next = 1'b0;
        lowHi_next = 1'b0;
      end
    endcase
    // Extra stage keeps the tick output straight from a flop
    tick_next = tickPulse; // [R17]
    // Tick count restarts while the clock module is held in reset
    if (td_reg[TD_RTC_RST]) begin
      tcnt_next = '0;
    end else if (tickPulse) begin
      tcnt_next = tcnt_reg + {{(TCNT_W-1){1'b0}}, 1'b1};
    end else begin
      tcnt_next = tcnt_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      switch_reg <= 1'b0;
      lowOn_reg <= 1'b0;
      lowHi_reg <= 1'b0;
      tick_reg <= 1'b0;
      tcnt_reg <= '0;
    end else begin
      switch_reg <= switch_next;
      lowOn_reg <= lowOn_next;
      lowHi_reg <= lowHi_next;
      tick_reg <= tick_next;
      tcnt_reg <= tcnt_next;
    end
  end

  assign railSwitchClosed = switch_reg;
  assign hiRailMonitorOff = pc_reg[PC_HI_MON_OFF]; // [R16]
  assign hiRailMonitorHystOff = pc_reg[PC_HI_HYST_OFF]; // [R16]
  assign hiRailMonitorHystLevel = pc_reg[PC_HI_HYST_LVL]; // [R16]
  assign loRailMonitorOff = pc_reg[PC_LO_MON_OFF]; // [R16]
  assign loRailMonitorHystOff = pc_reg[PC_LO_HYST_OFF]; // [R16]
  assign loRailMonitorHystLevel = pc_reg[PC_LO_HYST_LVL]; // [R16]
  assign hiRailOkCmpEnable = pc_reg[PC_OK_EN]; // [R16]
  assign hiRailNokCmpEnable = pc_reg[PC_NOK_EN]; // [R16]
  assign corePumpOff = pc_reg[PC_PUMP_OFF]; // [R3]
  assign referenceHoldForce = pc_reg[PC_REF_HOLD]; // [R4]
  assign coreRegulatorOff = pc_reg[PC_CORE_OFF]; // [R3]
  assign coreRegulatorRetentionOn = pc_reg[PC_CORE_RET]; // [R3]
  assign lowRegulatorOn = lowOn_reg;
  assign lowRegulatorHighCurrent = lowHi_reg;
  assign converterLevelSelect = pl_reg[PL_CONV_SEL +: 2]; // [R6]
  assign converterLevelOffset = pl_reg[PL_CONV_OFS +: 3]; // [R6]
  assign crystalRegulatorOffset = pl_reg[PL_XTAL_OFS +: 3]; // [R7]
  assign lowRegulatorOffset = pl_reg[PL_LOW_OFS +: 3]; // [R8]
  assign rtcResetReq = td_reg[TD_RTC_RST]; // [R9]
  assign rtcTick = tick_reg;
endmodule

// file: hw/pcr_pkg.sv
// Purpose: Shared constants for the power control registers and tick divider
// Assumes: AXI4-Lite slave with 32-bit data, 16-bit byte address
// Notes: Register index is the printed offset cut to its low IDX_W bits; byte address is four times it
package pcr_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W = ADDR_W - 2;
  localparam int INT_W = 9;
  localparam int FRAC_W = 10;
  localparam int DEN_W = 11;
  localparam int CNT_W = 10;
  localparam int TCNT_W = 16;
  localparam int SYNC_W = 3;

  localparam logic [31:0] POWER_CONTROL_IDX = 32'h5000_0052;
  localparam logic [31:0] POWER_LEVEL_TRIM_IDX = 32'h5000_0054;
  localparam logic [31:0] RTC_TICK_DIVIDER_IDX = 32'h5000_424C;
  localparam logic [31:0] POWER_STATUS_IDX = 32'h5000_0056;
  localparam logic [IDX_W-1:0] PC_SEL = POWER_CONTROL_IDX[IDX_W-1:0];
  localparam logic [IDX_W-1:0] PL_SEL = POWER_LEVEL_TRIM_IDX[IDX_W-1:0];
  localparam logic [IDX_W-1:0] TD_SEL = RTC_TICK_DIVIDER_IDX[IDX_W-1:0];
  localparam logic [IDX_W-1:0] ST_SEL = POWER_STATUS_IDX[IDX_W-1:0];

  localparam logic [31:0] PC_RESET = 32'h0000_4000;
  localparam logic [31:0] PL_RESET = 32'h0000_1A3E;
  localparam logic [31:0] TD_RESET = 32'h0005_1EA8;
  localparam logic [31:0] PC_MASK = 32'h0000_FFFF;
  localparam logic [31:0] PL_MASK = 32'h0000_3FFF;
  localparam logic [31:0] TD_MASK = 32'h003F_FFFF;

  localparam int PC_AUTO = 15;
  localparam int PC_HI_HYST_OFF = 14;
  localparam int PC_HI_HYST_LVL = 13;
  localparam int PC_HI_MON_OFF = 12;
  localparam int PC_LO_HYST_OFF = 11;
  localparam int PC_LO_HYST_LVL = 10;
  localparam int PC_LO_MON_OFF = 9;
  localparam int PC_PUMP_OFF = 8;
  localparam int PC_REF_HOLD = 7;
  localparam int PC_LOW_MODE = 5;
  localparam int PC_CORE_OFF = 4;
  localparam int PC_CORE_RET = 3;
  localparam int PC_CLOSE = 2;
  localparam int PC_OK_EN = 1;
  localparam int PC_NOK_EN = 0;

  localparam int PL_CONV_OFS = 11;
  localparam int PL_CONV_SEL = 9;
  localparam int PL_XTAL_OFS = 4;
  localparam int PL_LOW_OFS = 1;

  localparam int TD_RTC_RST = 21;
  localparam int TD_EN = 20;
  localparam int TD_DENOM = 19;
  localparam int TD_INT = 10;
  localparam int TD_FRAC = 0;

  localparam int ST_BOOST = 0;
  localparam int ST_AUTO_REQ = 1;
  localparam int ST_SWITCH = 2;
  localparam int ST_SLEEP = 3;
  localparam int ST_TCNT = 16;

  localparam logic [DEN_W-1:0] DENOM_1000 = 11'h3E8;
  localparam logic [DEN_W-1:0] DENOM_1024 = 11'h400;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    LOW_HI_OFF = 2'h0,
    LOW_OFF = 2'h1,
    LOW_LO_LO = 2'h2,
    LOW_HI_LO = 2'h3
  } pcr_low_mode_type;

  typedef enum logic {
    DIV_IDLE = 1'h0,
    DIV_RUN = 1'h1
  } pcr_div_state_type;
endpackage

// file: hw/pcr_tick_div.sv
// Purpose: Fractional divider making the real-time clock tick
// Assumes: Settings are static flops on the same clock
// Notes: Accumulator spreads the lengthened periods evenly
`timescale 1ns/1ps
module pcr_tick_div (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic denomSel,
  input wire logic [pcr_pkg::INT_W-1:0] intDiv,
  input wire logic [pcr_pkg::FRAC_W-1:0] fracDiv,
  output logic tick
);
  import pcr_pkg::*;

  pcr_div_state_type state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [DEN_W-1:0] acc_reg, acc_next;
  logic tick_reg, tick_next;
  logic [DEN_W-1:0] den, fracEff, accAdv;
  logic [DEN_W:0] sum;
  logic stretch;
  logic [CNT_W-1:0] len;

  always_comb begin
    den = denomSel ? DENOM_1024 : DENOM_1000; // [R11]
    // Fraction above the denominator would grow the accumulator unbounded
    fracEff = ({1'b0, fracDiv} > den) ? den : {1'b0, fracDiv};
    sum = {1'b0, acc_reg} + {1'b0, fracEff}; // [R17]
    stretch = sum >= {1'b0, den}; // [R14] [R15]
    accAdv = stretch ? DEN_W'(sum - {1'b0, den}) : sum[DEN_W-1:0];
    len = {1'b0, intDiv} + {{(CNT_W-1){1'b0}}, stretch}; // [R12] [R13]
    if (len == '0) begin
      len = {{(CNT_W-1){1'b0}}, 1'b1};
    end
    state_next = state_reg;
    cnt_next = cnt_reg;
    acc_next = acc_reg;
    tick_next = 1'b0;
    case (state_reg)
      DIV_IDLE: begin
        if (enable) begin
          state_next = DIV_RUN;
          cnt_next = len;
          acc_next = accAdv;
        end
      end
      DIV_RUN: begin
        if (!enable) begin // [R10]
          state_next = DIV_IDLE;
          cnt_next = '0;
          acc_next = '0;
        end else if (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1}) begin
          tick_next = 1'b1; // [R17]
          cnt_next = len;
          acc_next = accAdv;
        end else begin
          cnt_next = cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        state_next = DIV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= DIV_IDLE;
      cnt_reg <= '0;
      acc_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      acc_reg <= acc_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule

// file: hw/pcr_axil_slave.sv
// Purpose: AXI4-Lite slave front end issuing one-cycle register requests
// Assumes: Decode and read data come back combinationally in the request cycle
// Notes: One write and one read in flight; answers are registered
`timescale 1ns/1ps
module pcr_axil_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [pcr_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [pcr_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [pcr_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [pcr_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wrReq,
  output logic [pcr_pkg::IDX_W-1:0] wrIdx,
  output logic [pcr_pkg::DATA_W-1:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrHit,
  output logic rdReq,
  output logic [pcr_pkg::IDX_W-1:0] rdIdx,
  input wire logic [pcr_pkg::DATA_W-1:0] rdData,
  input wire logic rdHit
);
  import pcr_pkg::*;

  logic haveAw_reg, haveAw_next, haveW_reg, haveW_next, haveAr_reg, haveAr_next;
  logic [IDX_W-1:0] awIdx_reg, awIdx_next, arIdx_reg, arIdx_next;
  logic [DATA_W-1:0] wData_reg, wData_next, rdata_reg, rdata_next;
  logic [3:0] wStrb_reg, wStrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;

  always_comb begin
    haveAw_next = haveAw_reg;
    haveW_next = haveW_reg;
    haveAr_next = haveAr_reg;
    awIdx_next = awIdx_reg;
    arIdx_next = arIdx_reg;
    wData_next = wData_reg;
    wStrb_next = wStrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    wrReq = haveAw_reg && haveW_reg && !bvalid_reg;
    rdReq = haveAr_reg && !rvalid_reg;
    if (awvalid && awready_reg) begin
      haveAw_next = 1'b1;
      awIdx_next = awaddr[ADDR_W-1:2];
    end
    if (wvalid && wready_reg) begin
      haveW_next = 1'b1;
      wData_next = wdata;
      wStrb_next = wstrb;
    end
    if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (wrReq) begin
      haveAw_next = 1'b0;
      haveW_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wrHit ? RESP_OKAY : RESP_SLVERR;
    end
    if (arvalid && arready_reg) begin
      haveAr_next = 1'b1;
      arIdx_next = araddr[ADDR_W-1:2];
    end
    if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
    if (rdReq) begin
      haveAr_next = 1'b0;
      rvalid_next = 1'b1;
      rdata_next = rdHit ? rdData : '0;
      rresp_next = rdHit ? RESP_OKAY : RESP_SLVERR;
    end
    // Ready only while the holding slot and the answer are both free
    awready_next = !haveAw_next && !bvalid_next;
    wready_next = !haveW_next && !bvalid_next;
    arready_next = !haveAr_next && !rvalid_next;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      haveAw_reg <= 1'b0;
      haveW_reg <= 1'b0;
      haveAr_reg <= 1'b0;
      awIdx_reg <= '0;
      arIdx_reg <= '0;
      wData_reg <= '0;
      wStrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      arready_reg <= 1'b0;
    end else begin
      haveAw_reg <= haveAw_next;
      haveW_reg <= haveW_next;
      haveAr_reg <= haveAr_next;
      awIdx_reg <= awIdx_next;
      arIdx_reg <= arIdx_next;
      wData_reg <= wData_next;
      wStrb_reg <= wStrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      arready_reg <= arready_next;
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign arready = arready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign wrIdx = awIdx_reg;
  assign wrData = wData_reg;
  assign wrStrb = wStrb_reg;
  assign rdIdx = arIdx_reg;
endmodule

// file: test/pcr_top_sva.sv
// Purpose: Port-level checks for the power registers and tick divider
// Assumes: One clock, synchronous active-low reset
// Notes: Write checks assume address and data are offered together
`timescale 1ns/1ps
module pcr_top_sva
  import pcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [pcr_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic railSwitchClosed,
  input wire logic hiRailMonitorHystOff,
  input wire logic [1:0] converterLevelSelect,
  input wire logic [2:0] lowRegulatorOffset,
  input wire logic rtcTick
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_reset_values: assert property (
    $rose(rst_n) |-> !s_axi_bvalid && !rtcTick && !railSwitchClosed && hiRailMonitorHystOff
      && lowRegulatorOffset == 3'h7 && converterLevelSelect == 2'h1)
    else $error("bad state after reset");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  a_b_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_retire: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == '0)
    else $error("error read not zero");
  a_tick_pulse: assert property (rtcTick |=> !rtcTick)
    else $error("tick wider than one cycle");
endmodule

bind pcr_top pcr_top_sva chk (.*);

// file: test/tb_top.sv
// Purpose: Self-checking bench for the power registers and tick divider
// Assumes: Registers reached over AXI4-Lite at four times the index
// Notes: Divider runs with small divisors to keep the run short
`timescale 1ns/1ps
module tb_top;
  import pcr_pkg::*;
  localparam logic [15:0] PC_A = 16'h0148;
  localparam logic [15:0] PL_A = 16'h0150;
  localparam logic [15:0] TD_A = 16'h0930;
  logic clk, rst_n;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, converterLevelSelect;
  logic [2:0] converterLevelOffset, crystalRegulatorOffset, lowRegulatorOffset;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, boostMode, railAutoCloseReq;
  logic sleepActive, railSwitchClosed, hiRailMonitorOff, hiRailMonitorHystOff;
  logic hiRailMonitorHystLevel, loRailMonitorOff, loRailMonitorHystOff, loRailMonitorHystLevel;
  logic hiRailOkCmpEnable, hiRailNokCmpEnable, corePumpOff, referenceHoldForce, coreRegulatorOff;
  logic coreRegulatorRetentionOn, lowRegulatorOn, lowRegulatorHighCurrent, rtcResetReq, rtcTick;
  logic [15:0] ctrlVec;
  int fail_count = 0;
  int check_count = 0;

  pcr_top dut (.*);

  // Outputs placed at their control bit positions
  assign ctrlVec = {1'b0, hiRailMonitorHystOff, hiRailMonitorHystLevel, hiRailMonitorOff,
    loRailMonitorHystOff, loRailMonitorHystLevel, loRailMonitorOff, corePumpOff,
    referenceHoldForce, 2'h0, coreRegulatorOff, coreRegulatorRetentionOn, railSwitchClosed,
    hiRailOkCmpEnable, hiRailNokCmpEnable};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask

  task automatic t_reset;
    rd(PC_A, 32'h0000_4000, 2'h0);
    rd(PL_A, {18'h0, 3'h3, 2'h1, 2'h0, 3'h3, 3'h7, 1'h0}, 2'h0);
    rd(TD_A, {13'h0, 9'h147, 10'h2A8}, 2'h0);
    chk({crystalRegulatorOffset, converterLevelOffset}, 6'h1B);
    $display("done reset");
  endtask

  task automatic t_ctrl;
    for (int i = 0; i < 15; i++) begin
      if (i == 5 || i == 6) continue;
      wr(PC_A, 32'h1 << i, 2'h0);
      repeat (3) @(posedge clk);
      chk(ctrlVec, 16'h1 << i);
      rd(PC_A, 32'h1 << i, 2'h0);
    end
    $display("done ctrl");
  endtask

  task automatic t_low;
    logic [15:0] tbl;
    tbl = 16'hBA03;
    for (int m = 0; m < 8; m++) begin
      sleepActive <= m[0];
      wr(PC_A, {25'h0, m[2:1], 5'h0}, 2'h0);
      repeat (5) @(posedge clk);
      chk({lowRegulatorOn, lowRegulatorHighCurrent}, tbl[2*m +: 2]);
    end
    $display("done low mode");
  endtask

  task automatic t_switch;
    boostMode <= 1'b1;
    railAutoCloseReq <= 1'b1;
    wr(PC_A, 32'h0000_8000, 2'h0);
    repeat (5) @(posedge clk);
    chk(railSwitchClosed, 1'b1);
    railAutoCloseReq <= 1'b0;
    repeat (5) @(posedge clk);
    chk(railSwitchClosed, 1'b0);
    boostMode <= 1'b0;
    railAutoCloseReq <= 1'b1;
    repeat (5) @(posedge clk);
    chk(railSwitchClosed, 1'b0);
    rd(16'h0158, 32'h0000_000A, 2'h0);
    $display("done switch");
  endtask

  task automatic t_level;
    wr(PL_A, 32'hFFFF_FFFF, 2'h0);
    rd(PL_A, 32'h0000_3FFF, 2'h0);
    wr(PL_A, {18'h0, 3'h5, 2'h2, 2'h0, 3'h6, 3'h1, 1'h0}, 2'h0);
    repeat (2) @(posedge clk);
    chk({converterLevelOffset, converterLevelSelect, crystalRegulatorOffset,
      lowRegulatorOffset}, {3'h5, 2'h2, 3'h6, 3'h1});
    s_axi_wstrb <= 4'h1;
    wr(PL_A, 32'h0, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(PL_A, 32'h0000_2C00, 2'h0);
    wr(16'h0004, 32'hFFFF_FFFF, 2'h2);
    rd(16'h0004, 32'h0, 2'h2);
    $display("done level");
  endtask

  task automatic measure(input int n, input int base, input int frac);
    int gap, total;
    total = 0;
    for (int k = 0; k <= n; k++) begin
      gap = 0;
      do begin
        @(posedge clk);
        gap++;
      end while (rtcTick !== 1'b1 && gap < 2000);
      if (k > 0) begin
        chk(gap == base || gap == base + 1, 1'b1);
        total += gap;
      end
    end
    chk(total, n * base + frac);
  endtask

  task automatic t_div;
    logic [31:0] seen;
    seen = '0;
    wr(TD_A, {10'h0, 3'h4, 9'h004, 10'h1F4}, 2'h0);
    repeat (40) begin
      @(posedge clk);
      seen += rtcTick;
    end
    chk(seen, 0);
    chk(rtcResetReq, 1'b1);
    wr(TD_A, {10'h0, 3'h2, 9'h004, 10'h1F4}, 2'h0);
    measure(1000, 4, 500);
    chk(rtcResetReq, 1'b0);
    wr(TD_A, 32'h0, 2'h0);
    wr(TD_A, {10'h0, 3'h3, 9'h003, 10'h100}, 2'h0);
    measure(1024, 3, 256);
    $display("done divider");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    wrap_up;
  end

  initial begin
    rst_n = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {boostMode, railAutoCloseReq, sleepActive} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_ctrl;
    t_low;
    t_switch;
    t_level;
    t_div;
    wrap_up;
  end
endmodule
